// ==== core/timekeeper_irq_sync_regs.sv ====
// apb register block: interrupt enables, flags, debug control and sync busy of the timekeeper
`timescale 1ns/10ps
`default_nettype none
module timekeeper_irq_sync_regs #(
    parameter int TICK_DIV = timekeeper_pkg::TICK_DIV_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timekeeper_pkg::ADDR_W-1:0] paddr,
    input wire logic [timekeeper_pkg::DATA_W-1:0] pwdata,
    output logic [timekeeper_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_halted,
    output logic irq
);
    import timekeeper_pkg::*;

    logic halt_meta;
    logic halt_sync;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] next_prdata;
    logic [15:0] irq_enable;
    logic [15:0] irq_flags;
    logic run_while_halted;
    logic st_soft_reset;
    logic st_enable;
    logic st_count_read_sync;
    logic [7:0] st_rate_trim;
    logic [15:0] st_count;
    logic [15:0] st_wrap_limit;
    logic run_enable;
    logic count_read_sync_enable;
    logic [7:0] rate_trim;
    logic [15:0] count;
    logic [15:0] count_snapshot;
    logic [15:0] wrap_limit;
    logic [PRESC_W-1:0] prescaler;
    logic [PRESC_W-1:0] tap_rise;
    logic ovf_pending;
    logic [15:0] div_cnt;
    logic tick;
    logic running;
    logic [SYNC_W-1:0] sync_cnt [NUM_SYNC];
    logic [NUM_SYNC-1:0] sync_start;
    logic [NUM_SYNC-1:0] sync_done;
    logic [NUM_SYNC-1:0] busy;
    logic [31:0] sync_busy_status;
    logic soft_reset_now;
    logic write_ok;

    // debug halt comes from another domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            halt_meta <= 1'b0;
            halt_sync <= 1'b0;
        end
        else
        begin
            halt_meta <= debug_halted;
            halt_sync <= halt_meta;
        end
    end
    // apb handshake: one wait-free access, data registered in setup
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    // only soft reset control may be written while a soft reset runs
    assign write_ok = ~busy[CH_SOFT_RESET] | (paddr == byte_addr(IDX_MAIN_CONTROL)); // RULE_15
    assign wr = access & pwrite & write_ok;
    assign rd = access & ~pwrite;
    always_comb
    begin
        hit = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            byte_addr(IDX_MAIN_CONTROL):
            begin
                next_prdata[CTL_ENABLE] = st_enable;
                next_prdata[CTL_SOFT_RESET] = st_soft_reset;
                next_prdata[CTL_COUNT_READ_SYNC] = st_count_read_sync;
            end
            byte_addr(IDX_IRQ_ENABLE_CLEAR),
            byte_addr(IDX_IRQ_ENABLE_SET): next_prdata[15:0] = irq_enable; // RULE_04
            byte_addr(IDX_IRQ_FLAGS): next_prdata[15:0] = irq_flags;
            byte_addr(IDX_DEBUG_CONTROL): next_prdata[DBG_RUN_WHILE_HALTED] = run_while_halted;
            byte_addr(IDX_SYNC_BUSY_STATUS): next_prdata = sync_busy_status;
            byte_addr(IDX_RATE_TRIM): next_prdata[7:0] = rate_trim;
            byte_addr(IDX_COUNT):
                next_prdata[15:0] = count_read_sync_enable ? count_snapshot : count;
            byte_addr(IDX_WRAP_LIMIT): next_prdata[15:0] = st_wrap_limit;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~hit;
            if (setup)
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
    end
    // sync channels: a write loads a countdown, busy while nonzero
    always_comb
    begin
        sync_start = '0;
        if (wr && paddr == byte_addr(IDX_MAIN_CONTROL))
        begin
            sync_start[CH_SOFT_RESET] = pwdata[CTL_SOFT_RESET];
            sync_start[CH_ENABLE] = 1'b1;
            sync_start[CH_COUNT_READ_SYNC] = 1'b1;
        end
        sync_start[CH_RATE_TRIM] = wr && paddr == byte_addr(IDX_RATE_TRIM);
        sync_start[CH_WRAP_LIMIT] = wr && paddr == byte_addr(IDX_WRAP_LIMIT);
        sync_start[CH_COUNT] = (wr && paddr == byte_addr(IDX_COUNT))
            || (rd && paddr == byte_addr(IDX_COUNT) && count_read_sync_enable);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int c = 0; c < NUM_SYNC; c++)
                sync_cnt[c] <= '0;
        end
        else
        begin
            for (int c = 0; c < NUM_SYNC; c++)
            begin
                if (sync_start[c])
                    sync_cnt[c] <= SYNC_CYCLES; // RULE_16
                else if (soft_reset_now)
                    sync_cnt[c] <= '0;
                else if (sync_cnt[c] != '0)
                    sync_cnt[c] <= sync_cnt[c] - 1'b1;
            end
        end
    end

    always_comb
    begin
        for (int c = 0; c < NUM_SYNC; c++)
        begin
            busy[c] = sync_cnt[c] != '0;
            sync_done[c] = sync_cnt[c] == SYNC_W'(1);
        end
        sync_busy_status = RESET_SYNC_BUSY;
        sync_busy_status[CH_SOFT_RESET] = busy[CH_SOFT_RESET]; // RULE_14
        sync_busy_status[CH_ENABLE] = busy[CH_ENABLE]; // RULE_14
        sync_busy_status[CH_RATE_TRIM] = busy[CH_RATE_TRIM]; // RULE_14
        sync_busy_status[CH_COUNT] = busy[CH_COUNT]; // RULE_13
        sync_busy_status[CH_WRAP_LIMIT] = busy[CH_WRAP_LIMIT]; // RULE_12
        sync_busy_status[BUSY_COUNT_READ_SYNC_BIT] = busy[CH_COUNT_READ_SYNC]; // RULE_11
    end
    assign soft_reset_now = sync_done[CH_SOFT_RESET];
    // staged control values written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_soft_reset <= 1'b0;
            st_enable <= 1'b0;
            st_count_read_sync <= 1'b0;
            st_rate_trim <= RESET_RATE_TRIM;
            st_count <= RESET_COUNT;
            st_wrap_limit <= RESET_WRAP_LIMIT;
        end
        else if (soft_reset_now)
        begin
            st_soft_reset <= 1'b0;
            st_enable <= 1'b0;
            st_count_read_sync <= 1'b0;
            st_rate_trim <= RESET_RATE_TRIM;
            st_count <= RESET_COUNT;
            st_wrap_limit <= RESET_WRAP_LIMIT;
        end
        else
        begin
            if (sync_start[CH_ENABLE])
            begin
                st_soft_reset <= pwdata[CTL_SOFT_RESET];
                st_enable <= pwdata[CTL_ENABLE];
                st_count_read_sync <= pwdata[CTL_COUNT_READ_SYNC];
            end
            if (sync_start[CH_RATE_TRIM])
                st_rate_trim <= pwdata[7:0];
            if (sync_start[CH_COUNT] && pwrite)
                st_count <= pwdata[15:0];
            if (sync_start[CH_WRAP_LIMIT])
                st_wrap_limit <= pwdata[15:0];
        end
    end
    // values take effect when their sync completes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_enable <= 1'b0;
            count_read_sync_enable <= 1'b0;
            rate_trim <= RESET_RATE_TRIM;
            wrap_limit <= RESET_WRAP_LIMIT;
        end
        else if (soft_reset_now)
        begin
            run_enable <= 1'b0;
            count_read_sync_enable <= 1'b0;
            rate_trim <= RESET_RATE_TRIM;
            wrap_limit <= RESET_WRAP_LIMIT;
        end
        else
        begin
            if (sync_done[CH_ENABLE])
                run_enable <= st_enable;
            if (sync_done[CH_COUNT_READ_SYNC])
                count_read_sync_enable <= st_count_read_sync;
            if (sync_done[CH_RATE_TRIM])
                rate_trim <= st_rate_trim;
            if (sync_done[CH_WRAP_LIMIT])
                wrap_limit <= st_wrap_limit;
        end
    end
    // debug control survives soft reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_while_halted <= RESET_DEBUG_CONTROL[DBG_RUN_WHILE_HALTED];
        else if (wr && paddr == byte_addr(IDX_DEBUG_CONTROL))
            run_while_halted <= pwdata[DBG_RUN_WHILE_HALTED]; // RULE_10
    end
    // counter tick enable from the bus clock
    assign running = run_enable & (~halt_sync | run_while_halted); // RULE_09
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (div_cnt == 16'(TICK_DIV - 1))
            begin
                div_cnt <= 16'h0000;
                tick <= running;
            end
            else
                div_cnt <= div_cnt + 16'h0001;
        end
    end
    assign tap_rise = (prescaler + PRESC_W'(1)) & ~prescaler;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prescaler <= '0;
            count <= RESET_COUNT;
            ovf_pending <= 1'b0;
        end
        else if (soft_reset_now)
        begin
            prescaler <= '0;
            count <= RESET_COUNT;
            ovf_pending <= 1'b0;
        end
        else
        begin
            if (tick && running)
            begin
                prescaler <= prescaler + PRESC_W'(1);
                ovf_pending <= count == wrap_limit;
            end
            if (sync_done[CH_COUNT] && !count_read_sync_enable)
                count <= st_count;
            else if (tick && running)
                count <= (count == wrap_limit) ? 16'h0000 : count + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_snapshot <= RESET_COUNT;
        else if (sync_done[CH_COUNT] && count_read_sync_enable)
            count_snapshot <= count; // RULE_13
    end
    // enables: one state behind both views
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_enable <= RESET_IRQ_ENABLE;
        else if (soft_reset_now)
            irq_enable <= RESET_IRQ_ENABLE;
        else if (wr && paddr == byte_addr(IDX_IRQ_ENABLE_CLEAR))
            irq_enable <= irq_enable & ~(pwdata[15:0] & IRQ_MASK); // RULE_01 RULE_03
        else if (wr && paddr == byte_addr(IDX_IRQ_ENABLE_SET))
            irq_enable <= irq_enable | (pwdata[15:0] & IRQ_MASK); // RULE_02 RULE_03
    end
    // flags: hardware set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_flags <= RESET_IRQ_FLAGS;
        else if (soft_reset_now)
            irq_flags <= RESET_IRQ_FLAGS;
        else
        begin
            if (wr && paddr == byte_addr(IDX_IRQ_FLAGS))
                irq_flags <= (irq_flags & ~(pwdata[15:0] & IRQ_MASK)) // RULE_08
                    | {(tick & running & ovf_pending), 7'h00,
                       (tick & running) ? tap_rise[TAP_STAGE_OFS +: NUM_TAPS] : 8'h00};
            else
            begin
                if (tick && running && ovf_pending)
                    irq_flags[OVERFLOW_BIT] <= 1'b1; // RULE_05
                if (tick && running)
                    irq_flags[NUM_TAPS-1:0] <= irq_flags[NUM_TAPS-1:0]
                        | tap_rise[TAP_STAGE_OFS +: NUM_TAPS]; // RULE_07
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_flags & irq_enable); // RULE_06
    end
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence ovf_seen;
        tick && running && count == wrap_limit && !soft_reset_now;
    endsequence
    sequence ovf_next_tick;
        ovf_pending && tick && running && !soft_reset_now;
    endsequence
    chk_en_clear: assert property (wr && paddr == byte_addr(IDX_IRQ_ENABLE_CLEAR) // RULE_01
        && !soft_reset_now |=> (irq_enable & $past(pwdata[15:0]) & IRQ_MASK) == 16'h0000)
        else $error("enable clear left a bit set");
    chk_en_set: assert property (wr && paddr == byte_addr(IDX_IRQ_ENABLE_SET) // RULE_02
        && !soft_reset_now |=> (irq_enable & $past(pwdata[15:0]) & IRQ_MASK)
        == ($past(pwdata[15:0]) & IRQ_MASK))
        else $error("enable set missed a bit");
    chk_en_shared_read: assert property (setup && !pwrite && // RULE_03
        (paddr == byte_addr(IDX_IRQ_ENABLE_CLEAR) || paddr == byte_addr(IDX_IRQ_ENABLE_SET))
        |=> prdata[15:0] == $past(irq_enable)) // RULE_04
        else $error("enable read differs from enable state");
    chk_ovf_delay: assert property (ovf_seen |=> ovf_pending) // RULE_05
        else $error("overflow not pending after overflow");
    chk_ovf_flag: assert property (ovf_next_tick |=> irq_flags[OVERFLOW_BIT]) // RULE_05
        else $error("overflow flag not set on following tick");
    chk_irq_level: assert property (|(irq_flags & irq_enable) |=> irq ##1 // RULE_06
        (irq || $past(!(|(irq_flags & irq_enable)))))
        else $error("interrupt not raised for enabled flag");
    chk_tap_rise: assert property (tick && running && !soft_reset_now |=> // RULE_07
        (irq_flags[NUM_TAPS-1:0] & $past(tap_rise[TAP_STAGE_OFS +: NUM_TAPS]))
        == $past(tap_rise[TAP_STAGE_OFS +: NUM_TAPS]))
        else $error("tap flag not set on prescaler rise");
    chk_flag_clear: assert property (wr && paddr == byte_addr(IDX_IRQ_FLAGS) && !tick // RULE_08
        |=> (irq_flags & $past(pwdata[15:0]) & IRQ_MASK) == 16'h0000)
        else $error("flag not cleared by written one");
    chk_halt_stop: assert property (halt_sync && !run_while_halted && !soft_reset_now // RULE_09
        |=> $stable(prescaler))
        else $error("prescaler moved during debug halt");
    chk_dbg_keep: assert property (soft_reset_now && !wr |=> $stable(run_while_halted)) // RULE_10
        else $error("soft reset changed run-while-halted");
    chk_wrap_busy: assert property (sync_start[CH_WRAP_LIMIT] && !soft_reset_now // RULE_12
        |=> sync_busy_status[CH_WRAP_LIMIT][*3] ##1
        (!sync_busy_status[CH_WRAP_LIMIT] || $past(sync_start[CH_WRAP_LIMIT], 1)))
        else $error("wrap limit busy window wrong");
    chk_busy_unused: assert property (sync_busy_status[31:16] == 16'h0000 // RULE_16
        && sync_busy_status[14:5] == 10'h000)
        else $error("unused busy bit set");
endmodule : timekeeper_irq_sync_regs
`default_nettype wire

// ==== common/timekeeper_pkg.sv ====
// constants, register map and field layout of the timekeeper interrupt and sync block
// Behaviour
// RULE_01: ones written to enable-clear disable matching interrupts
// RULE_02: ones written to enable-set enable matching interrupts
// RULE_03: set and clear views share one enable state
// RULE_04: enable reads show one where interrupt enabled
// RULE_05: overflow flag sets one tick after overflow
// RULE_06: enabled set flag raises the interrupt request
// RULE_07: tap flag n sets on prescaler bit n+2 rise
// RULE_08: writing one clears a flag, zero keeps it
// RULE_09: debug halt stops counting unless run bit set
// RULE_10: run-while-halted bit survives soft reset
// RULE_11: busy bit 15 tracks count-read-sync enable write
// RULE_12: busy bit 4 tracks wrap-limit write sync
// RULE_13: busy bit 3 tracks counter read/write sync
// RULE_14: busy bits 2..0 track trim, enable, soft reset
// RULE_15: software touches only soft reset while it runs
// RULE_16: busy bits read-only, hardware driven, unused zero
package timekeeper_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int PRESC_W = 10;
    localparam int NUM_TAPS = 8;
    localparam int TAP_STAGE_OFS = 2;
    localparam int NUM_SYNC = 6;
    localparam int SYNC_W = 2;
    localparam logic [SYNC_W-1:0] SYNC_CYCLES = 2'h3;
    localparam int TICK_DIV_DEFAULT = 25;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_MAIN_CONTROL = 8'h00;
    localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR = 8'h08;
    localparam logic [7:0] IDX_IRQ_ENABLE_SET = 8'h0a;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_DEBUG_CONTROL = 8'h0e;
    localparam logic [7:0] IDX_SYNC_BUSY_STATUS = 8'h10;
    localparam logic [7:0] IDX_RATE_TRIM = 8'h14;
    localparam logic [7:0] IDX_COUNT = 8'h18;
    localparam logic [7:0] IDX_WRAP_LIMIT = 8'h1c;
    // field positions
    localparam int OVERFLOW_BIT = 15;
    localparam logic [15:0] IRQ_MASK = 16'h80ff;
    localparam int CTL_SOFT_RESET = 0;
    localparam int CTL_ENABLE = 1;
    localparam int CTL_COUNT_READ_SYNC = 15;
    localparam int DBG_RUN_WHILE_HALTED = 0;
    // sync channels in busy-bit order
    localparam int CH_SOFT_RESET = 0;
    localparam int CH_ENABLE = 1;
    localparam int CH_RATE_TRIM = 2;
    localparam int CH_COUNT = 3;
    localparam int CH_WRAP_LIMIT = 4;
    localparam int CH_COUNT_READ_SYNC = 5;
    localparam int BUSY_COUNT_READ_SYNC_BIT = 15;
    // reset values
    localparam logic [15:0] RESET_IRQ_ENABLE = 16'h0000;
    localparam logic [15:0] RESET_IRQ_FLAGS = 16'h0000;
    localparam logic [7:0] RESET_DEBUG_CONTROL = 8'h00;
    localparam logic [31:0] RESET_SYNC_BUSY = 32'h0000_0000;
    localparam logic [7:0] RESET_RATE_TRIM = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;
    localparam logic [15:0] RESET_WRAP_LIMIT = 16'h0000;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction : byte_addr
endpackage : timekeeper_pkg

// ==== tb/test_timekeeper_irq_sync_regs.sv ====
// self-checking bench for the timekeeper interrupt, debug and sync busy registers
`timescale 1ns/10ps
`default_nettype none
module test_timekeeper_irq_sync_regs;
    import timekeeper_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic debug_halted = 1'b0;
    logic irq;
    int n_mismatch = 0;
    int checks = 0;
    int seed = 49805;
    int en = 0;
    int fl = 0;
    logic [31:0] rdata;
    logic rerr;
    logic [31:0] v;
    logic [7:0] b_idx [4] = '{IDX_WRAP_LIMIT, IDX_RATE_TRIM, IDX_COUNT, IDX_MAIN_CONTROL};
    logic [31:0] b_dat [4] = '{32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002};
    logic [31:0] b_msk [4] = '{32'h0000_0010, 32'h0000_0004, 32'h0000_0008, 32'h0000_8002};

    timekeeper_irq_sync_regs #(.TICK_DIV(2)) dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .debug_halted(debug_halted),
        .irq(irq)
    );

    initial
    begin
        forever #20 pclk = ~pclk;
    end

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; holds the request until pready is sampled high
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= byte_addr(idx);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
            rdy = pready;
            rdata = prdata;
            rerr = pslverr;
            @(posedge pclk);
        end
        while (rdy !== 1'b1 && n < 16);
        if (rdy !== 1'b1)
        begin
            n_mismatch++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        check(rdata, exp);
    endtask : rd_chk

    task irq_chk;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check({31'h0, irq}, {31'h0, (fl & en) != 0});
    endtask : irq_chk

    initial
    begin
        #(40 * 20000);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(IDX_IRQ_ENABLE_CLEAR, 32'h0000_0000);
        rd_chk(IDX_IRQ_ENABLE_SET, 32'h0000_0000);
        rd_chk(IDX_IRQ_FLAGS, 32'h0000_0000);
        rd_chk(IDX_DEBUG_CONTROL, 32'h0000_0000);
        rd_chk(IDX_SYNC_BUSY_STATUS, 32'h0000_0000);
        $display("test reset_values done");
        for (int i = 0; i < 12; i++)
        begin
            v = $random(seed);
            if (v[16])
            begin
                apb(1'b1, IDX_IRQ_ENABLE_SET, {16'h0000, v[15:0]});
                en = en | (v[15:0] & 16'h80ff);
            end
            else
            begin
                apb(1'b1, IDX_IRQ_ENABLE_CLEAR, {16'h0000, v[15:0]});
                en = en & ~(v[15:0] & 16'h80ff);
            end
            rd_chk(IDX_IRQ_ENABLE_SET, en);
            rd_chk(IDX_IRQ_ENABLE_CLEAR, en);
        end
        $display("test enables done");
        apb(1'b1, 8'h04, 32'hffff_ffff);
        check({31'h0, rerr}, 32'h0000_0001);
        apb(1'b0, 8'h04, 32'h0000_0000);
        check({31'h0, rerr}, 32'h0000_0001);
        rd_chk(IDX_IRQ_ENABLE_SET, en);
        $display("test unmapped done");
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, b_idx[i], b_dat[i]);
            rd_chk(IDX_SYNC_BUSY_STATUS, b_msk[i]);
            repeat (8) @(posedge pclk);
            rd_chk(IDX_SYNC_BUSY_STATUS, 32'h0000_0000);
        end
        apb(1'b1, IDX_MAIN_CONTROL, 32'h0000_8002);
        repeat (8) @(posedge pclk);
        apb(1'b0, IDX_COUNT, 32'h0000_0000);
        rd_chk(IDX_SYNC_BUSY_STATUS, 32'h0000_0008);
        apb(1'b1, IDX_SYNC_BUSY_STATUS, 32'hffff_ffff);
        rd_chk(IDX_SYNC_BUSY_STATUS, 32'h0000_0000);
        $display("test sync_busy done");
        repeat (2200) @(posedge pclk);
        fl = 32'h0000_80ff;
        rd_chk(IDX_IRQ_FLAGS, fl);
        apb(1'b1, IDX_IRQ_ENABLE_SET, 32'h0000_8000);
        en = en | 32'h0000_8000;
        irq_chk();
        apb(1'b1, IDX_MAIN_CONTROL, 32'h0000_0000);
        repeat (8) @(posedge pclk);
        apb(1'b1, IDX_IRQ_FLAGS, 32'h0000_0000);
        rd_chk(IDX_IRQ_FLAGS, fl);
        apb(1'b1, IDX_IRQ_FLAGS, 32'h0000_0001);
        fl = 32'h0000_80fe;
        rd_chk(IDX_IRQ_FLAGS, fl);
        apb(1'b1, IDX_IRQ_FLAGS, 32'h0000_8000);
        fl = 32'h0000_00fe;
        irq_chk();
        apb(1'b1, IDX_IRQ_FLAGS, 32'h0000_ffff);
        fl = 0;
        rd_chk(IDX_IRQ_FLAGS, fl);
        irq_chk();
        $display("test flags done");
        debug_halted <= 1'b1;
        apb(1'b1, IDX_MAIN_CONTROL, 32'h0000_0002);
        repeat (2200) @(posedge pclk);
        rd_chk(IDX_IRQ_FLAGS, 32'h0000_0000);
        apb(1'b1, IDX_DEBUG_CONTROL, 32'h0000_0001);
        repeat (2200) @(posedge pclk);
        fl = 32'h0000_80ff;
        rd_chk(IDX_IRQ_FLAGS, fl);
        irq_chk();
        $display("test debug_halt done");
        apb(1'b1, IDX_MAIN_CONTROL, 32'h0000_0001);
        repeat (8) @(posedge pclk);
        en = 0;
        fl = 0;
        rd_chk(IDX_DEBUG_CONTROL, 32'h0000_0001);
        rd_chk(IDX_IRQ_ENABLE_SET, en);
        rd_chk(IDX_IRQ_FLAGS, fl);
        irq_chk();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(IDX_DEBUG_CONTROL, 32'h0000_0000);
        $display("test resets done");
        report_and_stop();
    end
endmodule : test_timekeeper_irq_sync_regs
`default_nettype wire
